/* verilog/crs_cfg.svh */
// Constants of the circular register stack: sizes, codes and reset values
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH

// ****************************************
// Bank geometry
// ****************************************
`define CRS_DEPTH        64
`define CRS_WIDTH        32
`define CRS_IDX_W        6
`define CRS_ENTRY_RESET  32'h0000_0000
`define CRS_STACK_OFFSET 6'h00

// ****************************************
// Computer mode addressing
// ****************************************
`define CRS_GROUP_W      8
`define CRS_GROUP_STACK  8'h01

// ****************************************
// Interrupt control setting that saves masks on the stack
// ****************************************
`define CRS_INT_MODE_W    8
`define CRS_INT_MODE_SAVE 8'h01

`endif

/* verilog/crs_pkg.sv */
// Types shared by the circular register stack design
`include "crs_cfg.svh"

package crs_pkg;

	// Access kinds on the command port
	typedef enum logic [1:0] {
		CRS_OP_PUSH  = 2'b00,
		CRS_OP_POP   = 2'b01,
		CRS_OP_READ  = 2'b10,
		CRS_OP_WRITE = 2'b11
	} crs_op_t;

	// Bank phase after reset
	typedef enum logic {
		CRS_PH_CLEAR = 1'b0,
		CRS_PH_RUN   = 1'b1
	} crs_phase_t;

	// Command from the program or a host in computer mode
	typedef struct packed {
		crs_op_t                      op;
		logic [`CRS_GROUP_W-1:0]      group;
		logic [`CRS_IDX_W-1:0]        member;
		logic signed [`CRS_WIDTH-1:0] data;
	} crs_req_t;

	// Answer to a command
	typedef struct packed {
		logic                         ack;
		logic                         err;
		logic                         rvalid;
		logic signed [`CRS_WIDTH-1:0] rdata;
	} crs_rsp_t;

	// All state of the stack controller
	typedef struct packed {
		crs_phase_t                   phase;
		logic [`CRS_IDX_W-1:0]        clr_cnt;
		logic [`CRS_IDX_W-1:0]        ptr;
		logic                         rd_user;
		logic                         rd_mask;
		logic                         ready;
		crs_rsp_t                     rsp;
		logic                         mask_valid;
		logic signed [`CRS_WIDTH-1:0] mask;
	} crs_state_t;

endpackage

/* verilog/crs_mem.sv */
// Storage array of the stack: one write port, one registered read port
`timescale 1ns/1ps
`default_nettype none

module crs_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	// Clock
	input  wire logic             clk_in,
	// Write port
	input  wire logic             we_in,
	input  wire logic [AW-1:0]    waddr_in,
	input  wire logic [WIDTH-1:0] wdata_in,
	// Read port
	input  wire logic [AW-1:0]    raddr_in,
	output logic      [WIDTH-1:0] rdata_out
);

	logic [WIDTH-1:0] mem_q [DEPTH];

	initial begin
		if (DEPTH != (1 << AW))
			$error("crs_mem: DEPTH must equal 2**AW");
	end

	always_ff @(posedge clk_in) begin
		if (we_in)
			mem_q[waddr_in] <= wdata_in;
		rdata_out <= mem_q[raddr_in];
	end

endmodule

`default_nettype wire

/* verilog/crs_stack.sv */
// Circular register stack: 64 signed words, push/pop and direct access
`timescale 1ns/1ps
`default_nettype none
`include "crs_cfg.svh"

// Behaviour
// - Bank of 64 signed 32-bit entries, each readable and writable by index.
// - Pushing past capacity raises no error; the oldest value is overwritten.
// - Push shifts entries up by one and writes the operand into entry zero.
// - Push discards the highest entry; the shift does not wrap.
// - Pop returns entry zero, then rotates down; old entry zero becomes top.
// - With interrupt control at setting 1, interrupt masks are pushed/popped here.
// - Computer mode addresses group 1, members 0 to 63, to reach this bank.
module crs_stack
	import crs_pkg::*;
#(
	parameter int DEPTH = `CRS_DEPTH,
	parameter int WIDTH = `CRS_WIDTH
) (
	// Clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rstn_in,
	// Command port
	input  wire logic                  req_valid_in,
	input  wire crs_pkg::crs_req_t     req_in,
	output logic                       ready_out,
	output crs_pkg::crs_rsp_t          rsp_out,
	// Interrupt mask save and restore
	input  wire logic [`CRS_INT_MODE_W-1:0] int_mode_in,
	input  wire logic                  mask_push_in,
	input  wire logic                  mask_pop_in,
	input  wire logic [`CRS_WIDTH-1:0] mask_in,
	output logic                       mask_valid_out,
	output logic [`CRS_WIDTH-1:0]      mask_out
);
	import crs_pkg::*;

	localparam int AW = `CRS_IDX_W;

	initial begin
		if (DEPTH != `CRS_DEPTH || WIDTH != `CRS_WIDTH)
			$error("crs_stack: only 64 entries of 32 bits are supported");
	end

	crs_state_t s_q;
	crs_state_t s_d;

	// Memory port wires
	logic             mem_we;
	logic [AW-1:0]    mem_waddr;
	logic [WIDTH-1:0] mem_wdata;
	logic [AW-1:0]    mem_raddr;
	logic [WIDTH-1:0] mem_rdata;

	// ****************************************
	// Storage
	// ****************************************
	// The bank is a ring addressed from a moving base, so a push or pop
	// costs one pointer step instead of shifting 64 words.
	crs_mem #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_mem (
		.clk_in    (clk_in),
		.we_in     (mem_we),
		.waddr_in  (mem_waddr),
		.wdata_in  (mem_wdata),
		.raddr_in  (mem_raddr),
		.rdata_out (mem_rdata)
	);

	// ****************************************
	// Control
	// ****************************************
	logic mask_ops;
	logic mask_push;
	logic mask_pop;
	logic take;
	logic hit;

	always_comb begin
		s_d       = s_q;
		mem_we    = 1'b0;
		mem_waddr = '0;
		mem_wdata = '0;
		mem_raddr = s_q.ptr;
		// Mask traffic only when interrupt control selects stack saves
		mask_ops  = (int_mode_in == `CRS_INT_MODE_SAVE);
		mask_push = mask_ops && mask_push_in;
		mask_pop  = mask_ops && mask_pop_in && !mask_push_in;
		// Interrupt mask pushes and pops win; a host request simply waits for a free cycle
		take      = s_q.ready && req_valid_in && !mask_push && !mask_pop;
		hit       = (req_in.group == `CRS_GROUP_STACK);

		s_d.rsp.ack    = 1'b0;
		s_d.rsp.err    = 1'b0;
		s_d.rsp.rvalid = s_q.rd_user;
		s_d.mask_valid = s_q.rd_mask;
		if (s_q.rd_user)
			s_d.rsp.rdata = mem_rdata;
		if (s_q.rd_mask)
			s_d.mask = mem_rdata;
		s_d.rd_user = 1'b0;
		s_d.rd_mask = 1'b0;

		unique case (s_q.phase)
			CRS_PH_CLEAR: begin
				// Sweep zeros through the ring, accepting nothing meanwhile
				mem_we      = 1'b1;
				mem_waddr   = s_q.clr_cnt;
				mem_wdata   = `CRS_ENTRY_RESET;
				s_d.clr_cnt = s_q.clr_cnt + 1'b1;
				if (s_q.clr_cnt == AW'(DEPTH - 1)) begin
					s_d.phase = CRS_PH_RUN;
					s_d.ready = 1'b1;
				end
			end
			CRS_PH_RUN: begin
				s_d.ready = !take;
				if (mask_push) begin
					// Same ring push as user data
					mem_we    = 1'b1;
					mem_waddr = s_q.ptr - 1'b1;
					mem_wdata = mask_in;
					s_d.ptr   = s_q.ptr - 1'b1;
				end else if (mask_pop) begin
					mem_raddr   = s_q.ptr;
					s_d.rd_mask = 1'b1;
					s_d.ptr     = s_q.ptr + 1'b1;
				end else if (take) begin
					s_d.rsp.ack = 1'b1;
					s_d.rsp.err = !hit;
					if (hit) begin
						unique case (req_in.op)
							CRS_OP_PUSH: begin
								// New entry zero lands on old entry 63's slot,
								// so the top value is dropped, never flagged
								mem_we    = 1'b1;
								mem_waddr = s_q.ptr - 1'b1;
								mem_wdata = req_in.data;
								s_d.ptr   = s_q.ptr - 1'b1;
							end
							CRS_OP_POP: begin
								// Old entry zero stays in its slot, now the top
								mem_raddr   = s_q.ptr;
								s_d.rd_user = 1'b1;
								s_d.ptr     = s_q.ptr + 1'b1;
							end
							CRS_OP_READ: begin
								mem_raddr   = s_q.ptr + req_in.member;
								s_d.rd_user = 1'b1;
							end
							CRS_OP_WRITE: begin
								mem_we    = 1'b1;
								mem_waddr = s_q.ptr + req_in.member;
								mem_wdata = req_in.data;
							end
						endcase
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign ready_out      = s_q.ready;
	assign rsp_out        = s_q.rsp;
	assign mask_valid_out = s_q.mask_valid;
	assign mask_out       = s_q.mask;

endmodule

`default_nettype wire

/* bench/crs_stack_monitor.sv */
// Port checker for the circular register stack
`timescale 1ns/1ps
`default_nettype none
`include "crs_cfg.svh"
module crs_stack_monitor
	import crs_pkg::*;
(
	input wire logic     clk_in,
	input wire logic     rstn_in,
	input wire logic     req_valid_in,
	input wire crs_req_t req_in,
	input wire logic     ready_out,
	input wire crs_rsp_t rsp_out,
	input wire logic [`CRS_INT_MODE_W-1:0] int_mode_in,
	input wire logic     mask_push_in,
	input wire logic     mask_pop_in,
	input wire logic [`CRS_WIDTH-1:0] mask_in,
	input wire logic     mask_valid_out,
	input wire logic [`CRS_WIDTH-1:0] mask_out
);
	// ****************
	// Properties
	// ****************
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	logic mop;
	// Mask traffic steals the cycle from the host
	assign mop = int_mode_in == `CRS_INT_MODE_SAVE && (mask_push_in || mask_pop_in);
	sequence s_take;
		ready_out && req_valid_in && !mop;
	endsequence
	sequence s_good;
		s_take ##0 req_in.group == `CRS_GROUP_STACK;
	endsequence
	ack_take_a: assert property (s_take |=> rsp_out.ack && !ready_out ##1 ready_out)
		else $error("no ack after take");
	bad_group_a: assert property (s_take ##0 req_in.group != 8'h01 |=> rsp_out.err)
		else $error("no err on wrong group");
	good_group_a: assert property (s_good |=> !rsp_out.err)
		else $error("err on group one");
	read_data_a: assert property (s_good ##0 req_in.op[1] != req_in.op[0] |-> ##2 rsp_out.rvalid)
		else $error("no read data");
	rvalid_src_a: assert property (rsp_out.rvalid |-> $past(rsp_out.ack) && !$past(rsp_out.err))
		else $error("stray read data");
	mask_ret_a: assert property (mask_pop_in && !mask_push_in && int_mode_in == 8'h01 && ready_out |-> ##2 mask_valid_out)
		else $error("no mask restore");
	mask_src_a: assert property (mask_valid_out |-> $past(mask_pop_in, 2) && $past(int_mode_in, 2) == 8'h01)
		else $error("stray mask restore");
	clear_sweep_a: assert property ($rose(rstn_in) |-> !ready_out [*8])
		else $error("ready during clear");
endmodule
bind crs_stack crs_stack_monitor u_mon (.clk_in, .rstn_in, .req_valid_in,
	.req_in, .ready_out, .rsp_out, .int_mode_in, .mask_push_in,
	.mask_pop_in, .mask_in, .mask_valid_out, .mask_out);
`default_nettype wire

/* bench/circular_register_stack_bench.sv */
// Self-checking bench for the circular register stack
`timescale 1ns/1ps
`default_nettype none
`include "crs_cfg.svh"
module circular_register_stack_bench;
	import crs_pkg::*;
	localparam logic [7:0] G = 8'h01;
	logic     clk_in, rstn_in, req_valid_in, ready_out, er, e;
	logic     mask_push_in, mask_pop_in, mask_valid_out;
	crs_req_t req_in;
	crs_rsp_t rsp_out;
	logic [7:0]  int_mode_in;
	logic [31:0] mask_in, mask_out, rd;
	int       n_errors = 0;
	int       total_checks = 0;
	crs_stack dut (.clk_in, .rstn_in, .req_valid_in, .req_in, .ready_out,
		.rsp_out, .int_mode_in, .mask_push_in, .mask_pop_in, .mask_in,
		.mask_valid_out, .mask_out);
	initial begin
		clk_in = 0;
		forever #50 clk_in = ~clk_in;
	end
	// ****************
	// Tasks
	// ****************
	task automatic results;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s exp %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick;
		@(posedge clk_in);
		#1;
	endtask
	// Holds the command until ack, result lands one cycle later
	task automatic cmd(input crs_op_t op, input logic [7:0] g,
		input logic [5:0] m, input logic [31:0] d);
		int n;
		n = 0;
		req_in = '{op, g, m, d};
		req_valid_in = 1;
		do begin
			tick;
			n++;
		end while (rsp_out.ack !== 1'b1 && n < 200);
		if (n >= 200) begin
			n_errors++;
			results;
		end
		er = rsp_out.err;
		req_valid_in = 0;
		tick;
		rd = rsp_out.rdata;
		if (op == CRS_OP_POP || op == CRS_OP_READ)
			check("rvalid", {31'h0, rsp_out.rvalid}, 32'h1);
	endtask
	task automatic scen_stack;
		cmd(CRS_OP_READ, G, 6'h3F, 32'h0);
		check("e63", rd, 32'h0);
		cmd(CRS_OP_PUSH, G, 6'h00, 32'hAAAA_0001);
		cmd(CRS_OP_PUSH, G, 6'h00, 32'hAAAA_0002);
		cmd(CRS_OP_POP, G, 6'h00, 32'h0);
		check("pop", rd, 32'hAAAA_0002);
		cmd(CRS_OP_READ, G, 6'h00, 32'h0);
		check("e0", rd, 32'hAAAA_0001);
		cmd(CRS_OP_READ, G, 6'h3F, 32'h0);
		check("e63", rd, 32'hAAAA_0002);
	endtask
	// Overfill by one: oldest value must fall off the top
	task automatic scen_wrap;
		e = 0;
		for (int k = 1; k <= 65; k++) begin
			cmd(CRS_OP_PUSH, G, 6'h00, 32'h100 + k);
			e = e | er;
		end
		check("err", {31'h0, e}, 32'h0);
		cmd(CRS_OP_READ, G, 6'h00, 32'h0);
		check("e0", rd, 32'h141);
		cmd(CRS_OP_READ, G, 6'h3F, 32'h0);
		check("e63", rd, 32'h102);
	endtask
	task automatic scen_direct;
		cmd(CRS_OP_WRITE, G, 6'h07, 32'hFFFF_FFF9);
		cmd(CRS_OP_WRITE, 8'h02, 6'h07, 32'h0);
		check("err", {31'h0, er}, 32'h1);
		cmd(CRS_OP_READ, G, 6'h07, 32'h0);
		check("e7", rd, 32'hFFFF_FFF9);
	endtask
	task automatic scen_mask(input logic [7:0] md, input logic v);
		int_mode_in = md;
		mask_in = 32'hC3;
		mask_push_in = 1;
		tick;
		mask_push_in = 0;
		mask_pop_in = 1;
		tick;
		mask_pop_in = 0;
		tick;
		check("mvld", {31'h0, mask_valid_out}, {31'h0, v});
		if (v)
			check("mask", mask_out, 32'hC3);
	endtask
	initial begin
		rstn_in = 0;
		req_valid_in = 0;
		req_in = '0;
		int_mode_in = 0;
		mask_push_in = 0;
		mask_pop_in = 0;
		mask_in = 0;
		repeat (10) tick;
		rstn_in = 1;
		scen_stack;
		scen_wrap;
		scen_direct;
		scen_mask(8'h01, 1'b1);
		scen_mask(8'h00, 1'b0);
		results;
	end
endmodule
`default_nettype wire
